// *** fdp_chipset_model.sv ***
// Chipset-side bus agent model facing the data-phase block
`timescale 1ns/1ps
`default_nettype none
module fdp_chipset_model (
    input  wire logic        mclk,
    input  wire logic [63:0] data,
    input  wire logic [3:0]  flags_n,
    input  wire logic [3:0]  stb_p_n,
    input  wire logic [3:0]  stb_n_n,
    input  wire logic        valid_n,
    input  wire logic        dev_oe_n,
    output logic             bus_clock,
    output logic      [63:0] m_data,
    output logic      [3:0]  m_flags_n,
    output logic      [3:0]  m_stb_p_n,
    output logic      [3:0]  m_stb_n_n,
    output logic             m_valid_n,
    output logic             m_pd_n
);
    logic [3:0]   prev_p_n;
    logic [3:0]   prev_n_n;
    logic [63:0]  dec;
    logic [132:0] cap_q[$];
    int           cap_t[$];
    int           cyc;

    // Common bus clock runs free, eight mclk periods long, each edge 1 ns after an mclk rise
    initial begin
        m_data = 64'h0;
        m_flags_n = 4'hF;
        m_stb_p_n = 4'hF;
        m_stb_n_n = 4'hF;
        m_valid_n = 1'b1;
        m_pd_n = 1'b1;
        bus_clock = 1'b0;
        #13;
        forever #32 bus_clock = ~bus_clock;
    end

    // Records each beat the device drives, decoded per group
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        prev_p_n <= stb_p_n;
        prev_n_n <= stb_n_n;
        if (!dev_oe_n && ((prev_p_n & ~stb_p_n) |
                          (prev_n_n & ~stb_n_n)) != 4'h0) begin
            for (int g = 0; g < 4; g++)
                dec[g*16 +: 16] = flags_n[g] ? data[g*16 +: 16]
                                             : ~data[g*16 +: 16];
            cap_q.push_back({valid_n, flags_n, data, dec});
            cap_t.push_back(cyc);
        end
    end

    // One slow beat; the strobe edges stay well apart for the synchronisers
    task automatic drive_beat(input logic [63:0] w, input logic [3:0] inv_n,
                              input logic use_p, input logic vld_n);
        logic [63:0] l;
        for (int g = 0; g < 4; g++)
            l[g*16 +: 16] = inv_n[g] ? w[g*16 +: 16] : ~w[g*16 +: 16];
        @(posedge mclk);
        m_data <= l;
        m_flags_n <= inv_n;
        m_valid_n <= vld_n;
        repeat (4) @(posedge mclk);
        if (use_p)
            m_stb_p_n <= 4'h0;
        else
            m_stb_n_n <= 4'h0;
        repeat (6) @(posedge mclk);
        m_stb_p_n <= 4'hF;
        m_stb_n_n <= 4'hF;
        repeat (4) @(posedge mclk);
        m_valid_n <= 1'b1;
        m_data <= ~l;
        m_flags_n <= ~inv_n;
    endtask
endmodule
`default_nettype wire

// *** fdp_data_phase.sv ***
// Device-side data phase: inverted quad-pumped send, strobed receive, sleep depth
`timescale 1ns/1ps
`default_nettype none
module fdp_data_phase #(
    parameter int BEAT_CYC = fdp_pkg::BEAT_CYC
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        bus_clock,
    input  wire logic [63:0] data_in,
    output logic      [63:0] data_out,
    output logic             data_oe_n,
    input  wire logic [3:0]  group_polarity_flags_in_n,
    output logic      [3:0]  group_polarity_flags_out_n,
    output logic             group_polarity_flags_oe_n,
    input  wire logic [3:0]  negative_data_strobes_in_n,
    output logic      [3:0]  negative_data_strobes_out_n,
    input  wire logic [3:0]  positive_data_strobes_in_n,
    output logic      [3:0]  positive_data_strobes_out_n,
    output logic             data_strobes_oe_n,
    input  wire logic        data_valid_indicator_in_n,
    output logic             data_valid_indicator_out_n,
    output logic             data_valid_indicator_oe_n,
    input  wire logic        input_buffer_power_down_in_n,
    output logic             input_buffer_power_down_out_n,
    output logic             input_buffer_power_down_oe_n,
    input  wire logic        deep_sleep_request_n,
    input  wire logic        deeper_sleep_request_n,
    input  wire logic        sleep_request,
    input  wire logic        freq_switch,
    input  wire logic        freq_switch_power_down,
    input  wire logic [63:0] tx_word,
    input  wire logic        tx_valid,
    output logic             tx_taken,
    output logic [63:0]      rx_data,
    output logic [3:0]       rx_group_valid,
    output logic             rx_buffers_off,
    output logic [1:0]       sleep_state
);
    localparam int SYNC_W = 64 + 4 + 4 + 4 + 1 + 1 + 1 + 1 + 1;
    localparam logic [3:0] BEAT_LAST = 4'(BEAT_CYC - 1);
    localparam logic [3:0] BEAT_MID  = 4'(BEAT_CYC / 2);
    initial begin
        if (BEAT_CYC < 2 || BEAT_CYC > 15) $error("BEAT_CYC must be 2..15");
    end
    logic [SYNC_W-1:0] sync_level;
    logic [63:0]       rx_lines;
    logic [3:0]        rx_flags_n;
    logic [3:0]        stb_n_s;
    logic [3:0]        stb_p_s;
    logic              dv_s_n;
    logic              pd_s_n;
    logic              deep_s_n;
    logic              deeper_s_n;
    logic              bclk_s;
    // Strobes and bus clock idle high; all pins share one sampling depth
    fdp_sync3 #(
        .WIDTH (SYNC_W),
        .INIT  ({64'h0, 4'hF, 4'hF, 4'hF, 5'h1F})
    ) u_sync (
        .mclk  (mclk),
        .rst   (rst),
        .ce    (ce),
        .pin   ({data_in, group_polarity_flags_in_n,
                 negative_data_strobes_in_n, positive_data_strobes_in_n,
                 data_valid_indicator_in_n, input_buffer_power_down_in_n,
                 deep_sleep_request_n, deeper_sleep_request_n, bus_clock}),
        .level (sync_level)
    );
    assign {rx_lines, rx_flags_n, stb_n_s, stb_p_s, dv_s_n, pd_s_n,
            deep_s_n, deeper_s_n, bclk_s} = sync_level;
    logic       bclk_q;
    logic [3:0] stb_n_q;
    logic [3:0] stb_p_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bclk_q  <= 1'b1;
            stb_n_q <= 4'hF;
            stb_p_q <= 4'hF;
        end else if (ce) begin
            bclk_q  <= bclk_s;
            stb_n_q <= stb_n_s;
            stb_p_q <= stb_p_s;
        end
    end
    logic       bclk_rise;
    logic [3:0] stb_fall;
    assign bclk_rise = bclk_s & ~bclk_q;
    assign stb_fall  = (stb_n_q & ~stb_n_s) | (stb_p_q & ~stb_p_s);
    // Send sequencer: a quad of four beats fills one bus clock period; quads start at most every other period
    logic       quad_busy;
    logic [1:0] beat;
    logic [3:0] cyc;
    logic       quad_start;
    logic       beat_load;
    assign quad_start = bclk_rise & tx_valid & ~quad_busy;
    assign beat_load  = quad_start
                      | (quad_busy & cyc == BEAT_LAST & beat != 2'h3);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            quad_busy <= 1'b0;
            beat      <= 2'h0;
            cyc       <= 4'h0;
        end else if (ce) begin
            if (quad_start) begin
                quad_busy <= 1'b1;
                beat      <= 2'h0;
                cyc       <= 4'h0;
            end else if (quad_busy) begin
                if (cyc == BEAT_LAST) begin
                    cyc  <= 4'h0;
                    beat <= beat + 2'h1;
                    if (beat == 2'h3) quad_busy <= 1'b0;
                end else begin
                    cyc <= cyc + 4'h1;
                end
            end
        end
    end
    // Data lines and flags change together at each beat load that sees tx_valid
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            data_out                   <= 64'h0;
            group_polarity_flags_out_n <= 4'hF;
            tx_taken                   <= 1'b0;
        end else if (ce) begin
            tx_taken <= beat_load & tx_valid;
            if (beat_load & tx_valid) begin
                {group_polarity_flags_out_n, data_out}
                    <= fdp_pkg::fdp_encode(data_out, tx_word);
            end
        end
    end
    // Strobes rise at a beat load and the beat's strobe falls mid-beat
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            positive_data_strobes_out_n <= 4'hF;
            negative_data_strobes_out_n <= 4'hF;
        end else if (ce) begin
            if (beat_load) begin
                positive_data_strobes_out_n <= 4'hF;
                negative_data_strobes_out_n <= 4'hF;
            end else if (quad_busy && cyc == BEAT_MID - 4'h1) begin
                if (beat[0]) negative_data_strobes_out_n <= 4'h0;
                else         positive_data_strobes_out_n <= 4'h0;
            end
        end
    end
    // Drivers are enabled for the whole quad; valid marks it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            data_oe_n                  <= 1'b1;
            group_polarity_flags_oe_n  <= 1'b1;
            data_strobes_oe_n          <= 1'b1;
            data_valid_indicator_out_n <= 1'b1;
            data_valid_indicator_oe_n  <= 1'b1;
        end else if (ce) begin
            if (quad_start) begin
                data_oe_n                  <= 1'b0;
                group_polarity_flags_oe_n  <= 1'b0;
                data_strobes_oe_n          <= 1'b0;
                data_valid_indicator_out_n <= 1'b0;
                data_valid_indicator_oe_n  <= 1'b0;
            end else if (quad_busy && beat == 2'h3 && cyc == BEAT_LAST) begin
                data_oe_n                  <= 1'b1;
                group_polarity_flags_oe_n  <= 1'b1;
                data_strobes_oe_n          <= 1'b1;
                data_valid_indicator_out_n <= 1'b1;
                data_valid_indicator_oe_n  <= 1'b1;
            end
        end
    end
    // Power-down pin: the device takes it over during frequency switching
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            input_buffer_power_down_oe_n  <= 1'b1;
            input_buffer_power_down_out_n <= 1'b1;
            rx_buffers_off                <= 1'b0;
        end else if (ce) begin
            input_buffer_power_down_oe_n  <= ~freq_switch;
            input_buffer_power_down_out_n <= ~freq_switch_power_down;
            rx_buffers_off <= freq_switch ? freq_switch_power_down
                                          : ~pd_s_n;
        end
    end
    // Receive: capture a group on its strobe fall while valid is shown
    logic [3:0]  rx_capture;
    logic [63:0] rx_plain;
    assign rx_capture = stb_fall & {4{~dv_s_n & ~rx_buffers_off & ~quad_busy}};
    assign rx_plain   = fdp_pkg::fdp_decode(rx_lines, rx_flags_n);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_data        <= 64'h0;
            rx_group_valid <= 4'h0;
        end else if (ce) begin
            rx_group_valid <= rx_capture;
            for (int g = 0; g < fdp_pkg::GROUPS; g++) begin
                if (rx_capture[g]) begin
                    rx_data[g*16 +: 16] <= rx_plain[g*16 +: 16];
                end
            end
        end
    end
    // Sleep depth follows the chipset's requests
    fdp_pkg::fdp_pstate_t pstate;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pstate <= fdp_pkg::FDP_RUN;
        end else if (ce) begin
            case (pstate)
                fdp_pkg::FDP_RUN:
                    if (sleep_request) pstate <= fdp_pkg::FDP_SLEEP;
                fdp_pkg::FDP_SLEEP:
                    if (!deep_s_n) pstate <= fdp_pkg::FDP_DEEP;
                    else if (!sleep_request) pstate <= fdp_pkg::FDP_RUN;
                fdp_pkg::FDP_DEEP:
                    if (!deeper_s_n) pstate <= fdp_pkg::FDP_DEEPER;
                    else if (deep_s_n) pstate <= fdp_pkg::FDP_SLEEP;
                fdp_pkg::FDP_DEEPER:
                    if (deeper_s_n) pstate <= fdp_pkg::FDP_DEEP;
                default:
                    pstate <= fdp_pkg::FDP_RUN;
            endcase
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) sleep_state <= 2'h0;
        else if (ce) sleep_state <= pstate;
    end
    logic [2:0] loads_in_quad;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) loads_in_quad <= 3'h0;
        else if (ce && quad_start) loads_in_quad <= 3'h1;
        else if (ce && beat_load) loads_in_quad <= loads_in_quad + 3'h1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_flag_polarity;
        ce && beat_load && tx_valid |=> {group_polarity_flags_out_n, data_out}
            == fdp_pkg::fdp_encode($past(data_out), $past(tx_word));
    endproperty
    a_flag_polarity: assert property (p_flag_polarity)
        else $error("flags do not match the inverted groups");
    property p_restore;
        ce && beat_load && tx_valid |=>
            fdp_pkg::fdp_decode(data_out, group_polarity_flags_out_n)
                == $past(tx_word);
    endproperty
    a_restore: assert property (p_restore)
        else $error("sent lines and flags do not restore the word");
    property p_change_limit;
        ce && beat_load && tx_valid |=>
            fdp_pkg::fdp_popcount(data_out[15:0] ^ $past(data_out[15:0]))
                <= 5'h0_8
            && fdp_pkg::fdp_popcount(data_out[63:48] ^ $past(data_out[63:48]))
                <= 5'h0_8;
    endproperty
    a_change_limit: assert property (p_change_limit)
        else $error("more than half of a group changed");
    property p_flags_with_data;
        group_polarity_flags_oe_n == data_oe_n && data_strobes_oe_n == data_oe_n;
    endproperty
    a_flags_with_data: assert property (p_flags_with_data)
        else $error("flags or strobes released apart from data");
    property p_valid_on_send;
        ce && quad_start |=> !data_valid_indicator_out_n
            && !data_valid_indicator_oe_n;
    endproperty
    a_valid_on_send: assert property (p_valid_on_send)
        else $error("data valid missing on a driven transfer");
    property p_four_beats;
        ce && quad_busy && beat == 2'h3 && cyc == BEAT_LAST
            |-> loads_in_quad == 3'h4;
    endproperty
    a_four_beats: assert property (p_four_beats)
        else $error("quad did not carry four beats");
    property p_no_idle_capture;
        |rx_group_valid |-> $past(!dv_s_n) && $past(|stb_fall);
    endproperty
    a_no_idle_capture: assert property (p_no_idle_capture)
        else $error("capture while data valid was withheld");
    property p_deeper_entry;
        ce && pstate == fdp_pkg::FDP_DEEP && !deeper_s_n
            |=> pstate == fdp_pkg::FDP_DEEPER ##1 sleep_state == 2'h3;
    endproperty
    a_deeper_entry: assert property (p_deeper_entry)
        else $error("deeper sleep not entered on request");
    property p_deep_entry;
        ce && pstate == fdp_pkg::FDP_SLEEP && !deep_s_n
            |=> pstate == fdp_pkg::FDP_DEEP;
    endproperty
    a_deep_entry: assert property (p_deep_entry)
        else $error("deep sleep not entered on request");
    property p_pd_drive;
        ce && freq_switch |=> !input_buffer_power_down_oe_n;
    endproperty
    a_pd_drive: assert property (p_pd_drive)
        else $error("power-down pin not driven during switching");
endmodule
`default_nettype wire

// *** fdp_pkg.sv ***
// Constants, timing and helper functions of the data-phase signalling block
package fdp_pkg;
    localparam int DATA_W        = 64;
    localparam int GROUPS        = 4;
    localparam int GROUP_W       = 16;
    localparam int BEATS         = 4;
    localparam int MCLK_PERIOD_NS = 8;
    localparam int BCLK_PERIOD_NS = 64;
    localparam int BEAT_CYC      = BCLK_PERIOD_NS / (MCLK_PERIOD_NS * BEATS);
    localparam int BEAT_HALF     = BEAT_CYC / 2;
    localparam int SYNC_STAGES   = 3;

    typedef enum logic [1:0] {
        FDP_RUN,
        FDP_SLEEP,
        FDP_DEEP,
        FDP_DEEPER
    } fdp_pstate_t;

    function automatic logic [4:0] fdp_popcount(input logic [15:0] v);
        logic [4:0] n;
        n = 5'h0_0;
        for (int i = 0; i < GROUP_W; i++) begin
            n = n + {4'h0, v[i]};
        end
        return n;
    endfunction

    // Returns {flags_n, lines}; flag low means the group is inverted
    function automatic logic [67:0] fdp_encode(input logic [63:0] prev,
                                               input logic [63:0] word);
        logic [63:0] lines;
        logic [3:0]  flags_n;
        lines   = word;
        flags_n = 4'hF;
        for (int g = 0; g < GROUPS; g++) begin
            if (fdp_popcount(prev[g*16 +: 16] ^ word[g*16 +: 16])
                    > 5'h0_8) begin
                lines[g*16 +: 16] = ~word[g*16 +: 16];
                flags_n[g]        = 1'b0;
            end
        end
        return {flags_n, lines};
    endfunction

    function automatic logic [63:0] fdp_decode(input logic [63:0] lines,
                                               input logic [3:0]  flags_n);
        logic [63:0] d;
        for (int g = 0; g < GROUPS; g++) begin
            d[g*16 +: 16] = flags_n[g] ? lines[g*16 +: 16]
                                       : ~lines[g*16 +: 16];
        end
        return d;
    endfunction
endpackage

// *** fdp_sync3.sv ***
// Three-stage pin synchroniser; the output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module fdp_sync3 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;

    initial begin
        if (WIDTH < 1) $error("fdp_sync3: WIDTH must be at least 1");
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1    <= INIT;
            s2    <= INIT;
            s3    <= INIT;
            level <= INIT;
        end else if (ce) begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < WIDTH; i++) begin
                if (s2[i] == s3[i]) begin
                    level[i] <= s3[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking testbench of the data-phase signalling block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        mclk, rst, ce, tx_valid, tx_taken, sleep_request;
    logic        freq_switch, freq_switch_power_down, rx_buffers_off;
    logic        deep_sleep_request_n, deeper_sleep_request_n;
    logic        data_oe_n, group_polarity_flags_oe_n, data_strobes_oe_n;
    logic        data_valid_indicator_out_n, data_valid_indicator_oe_n;
    logic        input_buffer_power_down_out_n, input_buffer_power_down_oe_n;
    logic        bus_clock, m_valid_n, m_pd_n;
    logic [1:0]  sleep_state;
    logic [3:0]  group_polarity_flags_out_n, rx_group_valid, m_flags_n;
    logic [3:0]  negative_data_strobes_out_n, positive_data_strobes_out_n;
    logic [3:0]  m_stb_p_n, m_stb_n_n;
    logic [63:0] data_out, tx_word, rx_data, m_data;
    logic [67:0] rx_q[$];
    int          failures;
    int          check_count;

    // Each shared wire carries whichever side has its output enabled
    wire [63:0] data_in = data_oe_n ? m_data : data_out;
    wire [3:0]  group_polarity_flags_in_n = group_polarity_flags_oe_n ?
                    m_flags_n : group_polarity_flags_out_n;
    wire [3:0]  negative_data_strobes_in_n = data_strobes_oe_n ?
                    m_stb_n_n : negative_data_strobes_out_n;
    wire [3:0]  positive_data_strobes_in_n = data_strobes_oe_n ?
                    m_stb_p_n : positive_data_strobes_out_n;
    wire        data_valid_indicator_in_n = data_valid_indicator_oe_n ?
                    m_valid_n : data_valid_indicator_out_n;
    wire        input_buffer_power_down_in_n = input_buffer_power_down_oe_n ?
                    m_pd_n : input_buffer_power_down_out_n;

    fdp_data_phase dut (.mclk, .rst, .ce, .bus_clock, .data_in, .data_out,
        .data_oe_n, .group_polarity_flags_in_n, .group_polarity_flags_out_n,
        .group_polarity_flags_oe_n, .negative_data_strobes_in_n,
        .negative_data_strobes_out_n, .positive_data_strobes_in_n,
        .positive_data_strobes_out_n, .data_strobes_oe_n,
        .data_valid_indicator_in_n, .data_valid_indicator_out_n,
        .data_valid_indicator_oe_n, .input_buffer_power_down_in_n,
        .input_buffer_power_down_out_n, .input_buffer_power_down_oe_n,
        .deep_sleep_request_n, .deeper_sleep_request_n, .sleep_request,
        .freq_switch, .freq_switch_power_down, .tx_word, .tx_valid, .tx_taken,
        .rx_data, .rx_group_valid, .rx_buffers_off, .sleep_state);

    fdp_chipset_model u_chip (.mclk, .data(data_in),
        .flags_n(group_polarity_flags_in_n),
        .stb_p_n(positive_data_strobes_in_n),
        .stb_n_n(negative_data_strobes_in_n),
        .valid_n(data_valid_indicator_in_n), .dev_oe_n(data_strobes_oe_n),
        .bus_clock, .m_data, .m_flags_n, .m_stb_p_n, .m_stb_n_n, .m_valid_n,
        .m_pd_n);

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    always @(posedge mclk)
        if (!rst && rx_group_valid !== 4'h0)
            rx_q.push_back({rx_group_valid, rx_data});

    task automatic check(input logic [67:0] seen, input logic [67:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [67:0] exp_enc(input logic [63:0] p,
                                            input logic [63:0] w);
        logic [63:0] l;
        logic [3:0]  f;
        l = w;
        f = 4'hF;
        for (int g = 0; g < 4; g++) begin
            if ($countones(p[g*16 +: 16] ^ w[g*16 +: 16]) > 8) begin
                l[g*16 +: 16] = ~w[g*16 +: 16];
                f[g] = 1'b0;
            end
        end
        return {f, l};
    endfunction

    task automatic rx_expect(input logic [67:0] e, input int cnt);
        check(68'(rx_q.size()), 68'(cnt));
        if (rx_q.size() > 0)
            check(rx_q[$], e);
        rx_q.delete();
    endtask

    task automatic t_reset_values();
        check({data_oe_n, group_polarity_flags_oe_n, data_strobes_oe_n,
               data_valid_indicator_oe_n, input_buffer_power_down_oe_n,
               input_buffer_power_down_out_n, data_valid_indicator_out_n,
               tx_taken, rx_group_valid, sleep_state}, 14'h3F80);
        check(data_out, 64'h0);
    endtask

    // Next word is offered at the edge that shows the take pulse
    task automatic t_send_quad();
        logic [63:0] w [4] = '{64'h01FF_00FF_FFFF_0000, 64'hFFFF_FFFF_0000_0001,
                               64'h0000_FF00_0F0F_8001, 64'hAAAA_5555_FFFE_7FFF};
        logic [63:0] prev = 64'h0;
        logic [67:0] e;
        logic        idle_bad = 1'b0;
        @(posedge mclk);
        tx_word <= w[0];
        tx_valid <= 1'b1;
        for (int i = 1; i <= 4; i++) begin
            for (int n = 0; n < 40; n++) begin
                @(posedge mclk);
                if (tx_taken === 1'b1)
                    break;
            end
            if (i < 4)
                tx_word <= w[i];
            else
                tx_valid <= 1'b0;
        end
        repeat (2) @(posedge mclk);
        for (int n = 0; n < 16; n++) begin
            @(posedge mclk);
            if (data_valid_indicator_out_n !== 1'b1)
                idle_bad = 1'b1;
        end
        check(idle_bad, 1'b0);
        check(68'(u_chip.cap_q.size()), 68'd4);
        if (u_chip.cap_q.size() == 4)
            check(68'(u_chip.cap_t[3] - u_chip.cap_t[0]), 68'd6);
        for (int i = 0; i < 4 && i < u_chip.cap_q.size(); i++) begin
            e = exp_enc(prev, w[i]);
            check(u_chip.cap_q[i][131:64], e);
            check(u_chip.cap_q[i][63:0], w[i]);
            check(u_chip.cap_q[i][132], 1'b0);
            prev = e[63:0];
        end
    endtask

    task automatic t_receive();
        rx_q.delete();
        u_chip.drive_beat(64'h1234_8001_FFFF_0F0F, 4'hA, 1'b1, 1'b0);
        rx_expect({4'hF, 64'h1234_8001_FFFF_0F0F}, 1);
        u_chip.drive_beat(64'hCAFE_0000_7E7E_5A5A, 4'h0, 1'b0, 1'b0);
        rx_expect({4'hF, 64'hCAFE_0000_7E7E_5A5A}, 1);
        u_chip.drive_beat(64'h0F0F_1111_2222_3333, 4'hF, 1'b1, 1'b1);
        rx_expect(68'h0, 0);
    endtask

    task automatic t_gated();
        u_chip.m_pd_n <= 1'b0;
        for (int n = 0; n < 12 && rx_buffers_off !== 1'b1; n++)
            @(posedge mclk);
        check(rx_buffers_off, 1'b1);
        u_chip.drive_beat(64'h5555_AAAA_0001_8000, 4'hF, 1'b0, 1'b0);
        rx_expect(68'h0, 0);
        u_chip.m_pd_n <= 1'b1;
        for (int n = 0; n < 12 && rx_buffers_off !== 1'b0; n++)
            @(posedge mclk);
        check(rx_buffers_off, 1'b0);
    endtask

    task automatic t_freq_switch();
        freq_switch <= 1'b1;
        freq_switch_power_down <= 1'b1;
        for (int n = 0; n < 12 && input_buffer_power_down_oe_n !== 1'b0; n++)
            @(posedge mclk);
        check({input_buffer_power_down_oe_n, input_buffer_power_down_out_n,
               rx_buffers_off}, 3'h1);
        freq_switch_power_down <= 1'b0;
        for (int n = 0; n < 12 && input_buffer_power_down_out_n !== 1'b1; n++)
            @(posedge mclk);
        check({input_buffer_power_down_oe_n,
               input_buffer_power_down_out_n}, 2'h1);
        freq_switch <= 1'b0;
        for (int n = 0; n < 12 && input_buffer_power_down_oe_n !== 1'b1; n++)
            @(posedge mclk);
        check(input_buffer_power_down_oe_n, 1'b1);
    endtask

    task automatic wait_state(input logic [1:0] s);
        for (int n = 0; n < 30 && sleep_state !== s; n++)
            @(posedge mclk);
        check(sleep_state, s);
    endtask

    task automatic t_sleep();
        sleep_request <= 1'b1;
        wait_state(2'h1);
        deeper_sleep_request_n <= 1'b0;
        repeat (10) @(posedge mclk);
        check(sleep_state, 2'h1);
        deep_sleep_request_n <= 1'b0;
        wait_state(2'h3);
        deeper_sleep_request_n <= 1'b1;
        wait_state(2'h2);
        deep_sleep_request_n <= 1'b1;
        wait_state(2'h1);
        sleep_request <= 1'b0;
        wait_state(2'h0);
    endtask

    task automatic final_report();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        tx_valid = 1'b0;
        tx_word = 64'h0;
        sleep_request = 1'b0;
        freq_switch = 1'b0;
        freq_switch_power_down = 1'b0;
        deep_sleep_request_n = 1'b1;
        deeper_sleep_request_n = 1'b1;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        t_reset_values();
        t_send_quad();
        t_receive();
        t_gated();
        t_freq_switch();
        t_sleep();
        final_report();
    end

    initial begin
        #200_000;
        failures++;
        final_report();
    end
endmodule
`default_nettype wire
